// ==== mmod_pkg.sv ====
`default_nettype none

package mmod_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int AW   = 14;
    localparam int PMW  = 24;
    localparam int DMW  = 16;
    localparam int IOAW = 11;
    localparam int WCW  = 3;
    localparam int MRAW = 5;

    // ------------------------------------------------------------
    // Memory map
    // ------------------------------------------------------------
    localparam logic [AW-1:0] PM_OVL_BASE  = 14'h2000;
    localparam logic [AW-1:0] PM_INT_LAST  = 14'h1fff;
    localparam logic [AW-1:0] DM_INT_LAST  = 14'h3fdf;
    localparam logic [AW-1:0] DM_MMR_BASE  = 14'h3fe0;
    localparam logic [12:0]   DM_INT_WORDS = 13'h1fe0;
    localparam int            PM_WORDS     = 8192;
    localparam int            DM_WORDS     = 8160;
    localparam int            IO_WORDS     = 2048;

    // ------------------------------------------------------------
    // Overlay values
    // ------------------------------------------------------------
    localparam logic [1:0] OVL_NONE = 2'h0;
    localparam logic [1:0] OVL_ONE  = 2'h1;
    localparam logic [1:0] OVL_TWO  = 2'h2;

    // ------------------------------------------------------------
    // External access sources and timing
    // ------------------------------------------------------------
    localparam logic [1:0] SRC_FETCH = 2'h0;
    localparam logic [1:0] SRC_PM    = 2'h1;
    localparam logic [1:0] SRC_DM    = 2'h2;
    localparam logic [1:0] SRC_IO    = 2'h3;
    localparam logic [1:0] SYNC_TAIL = 2'h1;
    localparam logic [WCW-1:0] PM_WAIT_DEFAULT = 3'h0;

    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_STROBE = 2'b01,
        ST_TAIL   = 2'b10
    } mmod_state_t;

endpackage

`default_nettype wire

// ==== mmod_decoder.sv ====
`default_nettype none
// Summary of operation
// - Strap and program overlay select choose the program memory layout
// - Strap low: nonzero program overlay sends upper program window to external bus
// - Program overlay 1 drives A13 low, 2 high; A12:0 from address
// - Strap high: lower program 8K external, upper reserved; program overlay 2 still drives A13 high
// - Program overlay select is not tracked by loop logic
// - Overlay selects are never saved or restored automatically
// - Program RAM serves a fetch and a data access each cycle
// - Data overlay zero keeps lower data window internal
// - Nonzero data overlay sends lower data window to external bus
// - Data overlay 1 drives A13 low, 2 high; A12:0 from address
// - Top 32 data locations go to mapped registers, RAM below them
// - Internal RAM accesses complete in one cycle, mapped registers in two
// - External data accesses stretched by data wait count
// - I/O space has 2048 words; only low eleven address bits used
// - Separate I/O request port apart from data memory moves
// - Four 3-bit I/O wait counts give 0 to 7 wait states
// - I/O wait count chosen by address bits 10:9
module mmod_decoder
    import mmod_pkg::*;
#(
    parameter logic [WCW-1:0] PM_EXT_WAIT = PM_WAIT_DEFAULT
) (
    input  wire logic            mclk,
    input  wire logic            rst_b,
    input  wire logic            mode_b_pin,
    input  wire logic [1:0]      program_overlay_select,
    input  wire logic [1:0]      data_overlay_select,
    input  wire logic [WCW-1:0]  data_ext_wait_count,
    input  wire logic [WCW-1:0]  io_region_wait_count0,
    input  wire logic [WCW-1:0]  io_region_wait_count1,
    input  wire logic [WCW-1:0]  io_region_wait_count2,
    input  wire logic [WCW-1:0]  io_region_wait_count3,
    input  wire logic            fetch_req,
    input  wire logic [AW-1:0]   fetch_addr,
    output logic                 fetch_ack,
    output logic [PMW-1:0]       fetch_rdata,
    input  wire logic            pm_req,
    input  wire logic            pm_we,
    input  wire logic [AW-1:0]   pm_addr,
    input  wire logic [PMW-1:0]  pm_wdata,
    output logic                 pm_ack,
    output logic [PMW-1:0]       pm_rdata,
    input  wire logic            dm_req,
    input  wire logic            dm_we,
    input  wire logic [AW-1:0]   dm_addr,
    input  wire logic [DMW-1:0]  dm_wdata,
    output logic                 dm_ack,
    output logic [DMW-1:0]       dm_rdata,
    input  wire logic            io_req,
    input  wire logic            io_we,
    input  wire logic [IOAW-1:0] io_addr,
    input  wire logic [DMW-1:0]  io_wdata,
    output logic                 io_ack,
    output logic [DMW-1:0]       io_rdata,
    output logic                 core_wait,
    output logic                 mmr_sel,
    output logic                 mmr_we,
    output logic [MRAW-1:0]      mmr_addr,
    output logic [DMW-1:0]       mmr_wdata,
    input  wire logic [DMW-1:0]  mmr_rdata,
    output logic [AW-1:0]        ext_addr,
    output logic [PMW-1:0]       ext_data_out,
    output logic                 ext_data_oe,
    input  wire logic [PMW-1:0]  ext_data_in,
    output logic                 pms_b,
    output logic                 dms_b,
    output logic                 ioms_b,
    output logic                 ext_rd_b,
    output logic                 ext_wr_b
);

    // ------------------------------------------------------------
    // Decode functions
    // ------------------------------------------------------------
    function automatic logic pm_is_ext(input logic [AW-1:0] a,
                                       input logic [1:0]    ovl,
                                       input logic          mb);
        pm_is_ext = mb ? !a[13] : (a[13] && (ovl != OVL_NONE));
    endfunction

    function automatic logic pm_is_int(input logic [AW-1:0] a,
                                       input logic          mb);
        pm_is_int = !mb && (a <= PM_INT_LAST);
    endfunction

    function automatic logic [AW-1:0] ovl_addr(input logic [AW-1:0] a,
                                               input logic [1:0]    ovl);
        ovl_addr = {(ovl == OVL_TWO), a[12:0]};
    endfunction

    function automatic logic dm_is_ext(input logic [AW-1:0] a,
                                       input logic [1:0]    ovl);
        dm_is_ext = !a[13] && (ovl != OVL_NONE);
    endfunction

    function automatic logic dm_is_mmr(input logic [AW-1:0] a);
        dm_is_mmr = (a >= DM_MMR_BASE);
    endfunction

    function automatic logic dm_is_int(input logic [AW-1:0] a,
                                       input logic [1:0]    ovl);
        dm_is_int = !dm_is_ext(a, ovl) && !dm_is_mmr(a)
                    && (a[12:0] < DM_INT_WORDS);
    endfunction

    function automatic logic [1:0] first_pend(input logic [3:0] p);
        if (p[0]) begin
            first_pend = SRC_FETCH;
        end else if (p[1]) begin
            first_pend = SRC_PM;
        end else if (p[2]) begin
            first_pend = SRC_DM;
        end else begin
            first_pend = SRC_IO;
        end
    endfunction

    // ------------------------------------------------------------
    // Reset release and pin synchronisers
    // ------------------------------------------------------------
    logic [1:0]     rst_pipe;
    logic           rst_sync_b;
    logic           mode_meta;
    logic           mode_b_cfg;
    logic [PMW-1:0] din_meta;
    logic [PMW-1:0] din_sync;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rst_pipe <= 2'h0;
        end else begin
            rst_pipe <= {rst_pipe[0], 1'b1};
        end
    end

    assign rst_sync_b = rst_pipe[1];

    always_ff @(posedge mclk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            mode_meta  <= 1'b0;
            mode_b_cfg <= 1'b0;
            din_meta   <= '0;
            din_sync   <= '0;
        end else begin
            mode_meta  <= mode_b_pin;
            mode_b_cfg <= mode_meta;
            din_meta   <= ext_data_in;
            din_sync   <= din_meta;
        end
    end

    // ------------------------------------------------------------
    // Request decode
    // ------------------------------------------------------------
    logic [PMW-1:0] pm_ram [0:PM_WORDS-1];
    logic [DMW-1:0] dm_ram [0:DM_WORDS-1];
    logic [3:0]     pend;
    logic [1:0]     cur;
    logic [1:0]     next_src;
    logic           take;
    logic           f_ext;
    logic           p_ext;
    logic           d_ext;
    logic           d_mmr;
    logic           done;
    logic [WCW-1:0] io_wait;
    mmod_state_t    st;
    logic [WCW-1:0] cnt;
    logic [1:0]     tail;

    // Overlay selects are used live, so no copy exists to stack
    assign f_ext = fetch_req
        && pm_is_ext(fetch_addr, program_overlay_select, mode_b_cfg);
    assign p_ext = pm_req
        && pm_is_ext(pm_addr, program_overlay_select, mode_b_cfg);
    assign d_ext = dm_req && dm_is_ext(dm_addr, data_overlay_select);
    assign d_mmr = dm_req && dm_is_mmr(dm_addr);
    assign take      = !core_wait;
    assign core_wait = (pend != 4'h0) || mmr_sel;
    assign next_src  = first_pend(pend);
    assign done      = (st == ST_TAIL) && (tail == 2'h0);

    always_comb begin
        case (io_addr[10:9])
            2'h0:    io_wait = io_region_wait_count0;
            2'h1:    io_wait = io_region_wait_count1;
            2'h2:    io_wait = io_region_wait_count2;
            default: io_wait = io_region_wait_count3;
        endcase
    end

    // ------------------------------------------------------------
    // Held external requests
    // ------------------------------------------------------------
    logic [AW-1:0]  h_addr  [4];
    logic [PMW-1:0] h_wdata [4];
    logic           h_we    [4];
    logic [WCW-1:0] h_wait  [4];

    always_ff @(posedge mclk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            for (int i = 0; i < 4; i++) begin
                h_addr[i]  <= '0;
                h_wdata[i] <= '0;
                h_we[i]    <= 1'b0;
                h_wait[i]  <= '0;
            end
        end else if (take) begin
            h_addr[SRC_FETCH]  <= ovl_addr(fetch_addr,
                                           program_overlay_select);
            h_we[SRC_FETCH]    <= 1'b0;
            h_wdata[SRC_FETCH] <= '0;
            h_wait[SRC_FETCH]  <= PM_EXT_WAIT;
            h_addr[SRC_PM]     <= ovl_addr(pm_addr,
                                           program_overlay_select);
            h_we[SRC_PM]       <= pm_we;
            h_wdata[SRC_PM]    <= pm_wdata;
            h_wait[SRC_PM]     <= PM_EXT_WAIT;
            h_addr[SRC_DM]     <= ovl_addr(dm_addr,
                                           data_overlay_select);
            h_we[SRC_DM]       <= dm_we;
            h_wdata[SRC_DM]    <= {8'h00, dm_wdata};
            h_wait[SRC_DM]     <= data_ext_wait_count;
            // Upper three bits carry no meaning on I/O cycles
            h_addr[SRC_IO]     <= {3'h0, io_addr};
            h_we[SRC_IO]       <= io_we;
            h_wdata[SRC_IO]    <= {8'h00, io_wdata};
            h_wait[SRC_IO]     <= io_wait;
        end
    end

    // Set only when idle, so a clear can never meet a set
    always_ff @(posedge mclk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            pend <= 4'h0;
        end else if (take) begin
            pend <= {io_req, d_ext, p_ext, f_ext};
        end else if (done) begin
            pend[cur] <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // External bus sequencer
    // ------------------------------------------------------------
    // Two extra strobe cycles cover the input synchroniser
    always_ff @(posedge mclk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            st           <= ST_IDLE;
            cur          <= SRC_FETCH;
            cnt          <= '0;
            tail         <= 2'h0;
            ext_addr     <= '0;
            ext_data_out <= '0;
            ext_data_oe  <= 1'b0;
            pms_b        <= 1'b1;
            dms_b        <= 1'b1;
            ioms_b       <= 1'b1;
            ext_rd_b     <= 1'b1;
            ext_wr_b     <= 1'b1;
        end else begin
            case (st)
                ST_IDLE: begin
                    if (pend != 4'h0) begin
                        st           <= ST_STROBE;
                        cur          <= next_src;
                        cnt          <= h_wait[next_src];
                        ext_addr     <= h_addr[next_src];
                        ext_data_out <= h_wdata[next_src];
                        ext_data_oe  <= h_we[next_src];
                        ext_rd_b     <= h_we[next_src];
                        ext_wr_b     <= !h_we[next_src];
                        pms_b  <= !(next_src == SRC_FETCH
                                    || next_src == SRC_PM);
                        dms_b  <= !(next_src == SRC_DM);
                        ioms_b <= !(next_src == SRC_IO);
                    end
                end
                ST_STROBE: begin
                    if (cnt == 3'h0) begin
                        st   <= ST_TAIL;
                        tail <= SYNC_TAIL;
                    end else begin
                        cnt <= cnt - 3'h1;
                    end
                end
                ST_TAIL: begin
                    if (tail == 2'h0) begin
                        st          <= ST_IDLE;
                        ext_data_oe <= 1'b0;
                        pms_b       <= 1'b1;
                        dms_b       <= 1'b1;
                        ioms_b      <= 1'b1;
                        ext_rd_b    <= 1'b1;
                        ext_wr_b    <= 1'b1;
                    end else begin
                        tail <= tail - 2'h1;
                    end
                end
                default: st <= ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Internal RAM and mapped registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (take && pm_req && pm_we && pm_is_int(pm_addr, mode_b_cfg)) begin
            pm_ram[pm_addr[12:0]] <= pm_wdata;
        end
        if (take && dm_req && dm_we
            && dm_is_int(dm_addr, data_overlay_select)) begin
            dm_ram[dm_addr[12:0]] <= dm_wdata;
        end
    end

    always_ff @(posedge mclk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            mmr_sel   <= 1'b0;
            mmr_we    <= 1'b0;
            mmr_addr  <= '0;
            mmr_wdata <= '0;
        end else begin
            mmr_sel <= take && d_mmr;
            if (take) begin
                mmr_we    <= dm_we;
                mmr_addr  <= dm_addr[MRAW-1:0];
                mmr_wdata <= dm_wdata;
            end
        end
    end

    // ------------------------------------------------------------
    // Answers to the core
    // ------------------------------------------------------------
    // Reserved or unbacked addresses answer with zero and no side effect
    always_ff @(posedge mclk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            fetch_ack   <= 1'b0;
            pm_ack      <= 1'b0;
            dm_ack      <= 1'b0;
            io_ack      <= 1'b0;
            fetch_rdata <= '0;
            pm_rdata    <= '0;
            dm_rdata    <= '0;
            io_rdata    <= '0;
        end else begin
            fetch_ack <= 1'b0;
            pm_ack    <= 1'b0;
            dm_ack    <= 1'b0;
            io_ack    <= 1'b0;
            if (take && fetch_req && !f_ext) begin
                fetch_ack   <= 1'b1;
                fetch_rdata <= pm_is_int(fetch_addr, mode_b_cfg)
                    ? pm_ram[fetch_addr[12:0]] : '0;
            end else if (done && cur == SRC_FETCH) begin
                fetch_ack   <= 1'b1;
                fetch_rdata <= din_sync;
            end
            if (take && pm_req && !p_ext) begin
                pm_ack <= 1'b1;
                if (!pm_we) begin
                    pm_rdata <= pm_is_int(pm_addr, mode_b_cfg)
                        ? pm_ram[pm_addr[12:0]] : '0;
                end
            end else if (done && cur == SRC_PM) begin
                pm_ack <= 1'b1;
                if (!h_we[SRC_PM]) begin
                    pm_rdata <= din_sync;
                end
            end
            if (take && dm_req && !d_ext && !d_mmr) begin
                dm_ack <= 1'b1;
                if (!dm_we) begin
                    dm_rdata <= dm_is_int(dm_addr, data_overlay_select)
                        ? dm_ram[dm_addr[12:0]] : '0;
                end
            end else if (mmr_sel) begin
                dm_ack <= 1'b1;
                if (!mmr_we) begin
                    dm_rdata <= mmr_rdata;
                end
            end else if (done && cur == SRC_DM) begin
                dm_ack <= 1'b1;
                if (!h_we[SRC_DM]) begin
                    dm_rdata <= din_sync[DMW-1:0];
                end
            end
            if (done && cur == SRC_IO) begin
                io_ack <= 1'b1;
                if (!h_we[SRC_IO]) begin
                    io_rdata <= din_sync[DMW-1:0];
                end
            end
        end
    end

endmodule // mmod_decoder

`default_nettype wire

// ==== mmod_ext_model.sv ====
`default_nettype none
module mmod_ext_model (
    input  wire logic        mclk,
    input  wire logic [13:0] ext_addr,
    input  wire logic [23:0] ext_data_out,
    input  wire logic        ext_data_oe,
    input  wire logic        pms_b,
    input  wire logic        dms_b,
    input  wire logic        ioms_b,
    input  wire logic        ext_rd_b,
    input  wire logic        ext_wr_b,
    output logic [23:0]      ext_data_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [23:0] mem [bit [15:0]];
    logic [15:0] key;
    // Per-select stores, so a wrong select misses
    assign key = {!pms_b ? 2'h1 : (!dms_b ? 2'h2 : 2'h3), ext_addr};
    initial ext_data_in = 24'h0;
    // Idle bus toggles so stale data never passes
    always @(negedge mclk) begin
        if (!ext_wr_b && ext_data_oe) mem[key] = ext_data_out;
        if (!ext_rd_b) begin
            ext_data_in <= mem.exists(key) ? mem[key] : 24'h0;
        end else begin
            ext_data_in <= ~ext_data_in;
        end
    end
endmodule // mmod_ext_model
`default_nettype wire

// ==== mmod_decoder_asserts.sv ====
`default_nettype none
module mmod_decoder_asserts
    import mmod_pkg::*;
(
    input wire logic            mclk,
    input wire logic            rst_b,
    input wire logic            mode_b_pin,
    input wire logic [1:0]      program_overlay_select,
    input wire logic [1:0]      data_overlay_select,
    input wire logic [WCW-1:0]  data_ext_wait_count,
    input wire logic [WCW-1:0]  io_region_wait_count0,
    input wire logic [WCW-1:0]  io_region_wait_count1,
    input wire logic [WCW-1:0]  io_region_wait_count2,
    input wire logic [WCW-1:0]  io_region_wait_count3,
    input wire logic            pm_req,
    input wire logic [AW-1:0]   pm_addr,
    input wire logic            dm_req,
    input wire logic [AW-1:0]   dm_addr,
    input wire logic            dm_ack,
    input wire logic            io_ack,
    input wire logic            core_wait,
    input wire logic            mmr_sel,
    input wire logic [MRAW-1:0] mmr_addr,
    input wire logic [AW-1:0]   ext_addr,
    input wire logic            pms_b,
    input wire logic            dms_b,
    input wire logic            ioms_b,
    input wire logic            ext_rd_b,
    input wire logic            ext_wr_b
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // Strobe length counter
    // ----------------------------------------
    logic [3:0]     low_cnt;
    logic [WCW-1:0] io_w;
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            low_cnt <= 4'h0;
        end else begin
            low_cnt <= (!ext_rd_b || !ext_wr_b) ? low_cnt + 4'h1 : 4'h0;
        end
    end
    assign io_w = ext_addr[10] ?
        (ext_addr[9] ? io_region_wait_count3 : io_region_wait_count2) :
        (ext_addr[9] ? io_region_wait_count1 : io_region_wait_count0);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    chk_one_select: assert property (
        $onehot0({!pms_b, !dms_b, !ioms_b}))
        else $error("more than one select low");
    chk_io_top_bits: assert property (
        !ioms_b |-> ext_addr[13:11] == 3'h0)
        else $error("io top bits set");
    chk_dm_int_ack: assert property (
        dm_req && !core_wait && dm_addr[13] && dm_addr <= DM_INT_LAST
        |=> dm_ack) else $error("internal dm ack late");
    chk_mmr_fwd: assert property (
        dm_req && !core_wait && dm_addr >= DM_MMR_BASE
        |=> mmr_sel && mmr_addr == 5'($past(dm_addr)) ##1 dm_ack)
        else $error("mmr access wrong");
    chk_dm_ovl_addr: assert property (
        dm_req && !core_wait && !dm_addr[13] && data_overlay_select != 2'h0
        |-> ##2 !dms_b && ext_addr[12:0] == 13'($past(dm_addr, 2))
        && ext_addr[13] == ($past(data_overlay_select, 2) != OVL_ONE))
        else $error("dm ovl addr wrong");
    chk_pm_ovl_addr: assert property (
        pm_req && !core_wait && pm_addr[13] && !mode_b_pin
        && program_overlay_select != 2'h0
        |-> ##2 !pms_b && ext_addr[12:0] == 13'($past(pm_addr, 2))
        && ext_addr[13] == ($past(program_overlay_select, 2) != OVL_ONE))
        else $error("pm ovl addr wrong");
    chk_dm_wait: assert property (
        $rose(dms_b) |-> dm_ack
        && low_cnt == 4'(data_ext_wait_count) + 4'h3)
        else $error("dm strobe len wrong");
    chk_io_wait: assert property (
        $rose(ioms_b) |-> io_ack && low_cnt == 4'(io_w) + 4'h3)
        else $error("io strobe len wrong");
endmodule // mmod_decoder_asserts
bind mmod_decoder mmod_decoder_asserts u_chk (.*);
`default_nettype wire

// ==== mmod_decoder_bench.sv ====
`default_nettype none
module mmod_decoder_bench;
    import mmod_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [WCW-1:0] PMW_T = 3'h1;
    localparam logic [2:0] WT [4] = '{3'h0, 3'h3, 3'h5, 3'h7};
    logic            mclk, rst_b, mode_b_pin, ext_data_oe, core_wait;
    logic [1:0]      program_overlay_select, data_overlay_select;
    logic [WCW-1:0]  data_ext_wait_count;
    logic            fetch_req, pm_req, pm_we, dm_req, dm_we, io_req, io_we;
    logic            fetch_ack, pm_ack, dm_ack, io_ack, mmr_sel, mmr_we;
    logic            pms_b, dms_b, ioms_b, ext_rd_b, ext_wr_b;
    logic [AW-1:0]   fetch_addr, pm_addr, dm_addr, ext_addr;
    logic [IOAW-1:0] io_addr;
    logic [PMW-1:0]  pm_wdata, fetch_rdata, pm_rdata, ext_data_out, ext_data_in;
    logic [DMW-1:0]  dm_wdata, io_wdata, dm_rdata, io_rdata, mmr_wdata, mmr_rdata;
    logic [MRAW-1:0] mmr_addr;
    logic [3:0]      acks;
    int              n_errors, n_tests;
    assign mmr_rdata = 16'ha500 | {11'h0, mmr_addr};
    assign acks = {io_ack, dm_ack, pm_ack, fetch_ack};
    mmod_decoder #(.PM_EXT_WAIT(PMW_T)) u_mmod_decoder (.*,
        .io_region_wait_count0(WT[0]), .io_region_wait_count1(WT[1]),
        .io_region_wait_count2(WT[2]), .io_region_wait_count3(WT[3]));
    mmod_ext_model u_mmod_ext_model (.*);
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic chk(input string nm, input logic [23:0] e, g);
        n_tests++;
        if (g !== e) begin
            n_errors++;
            $display("Error %s: expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic acc(input int k, input logic we, input logic [13:0] a,
                       input logic [23:0] wd, output logic [23:0] rd,
                       output int lat);
        do @(negedge mclk); while (core_wait !== 1'b0);
        {io_req, dm_req, pm_req, fetch_req} = 4'h1 << k;
        {pm_we, dm_we, io_we} = {3{we}};
        {fetch_addr, pm_addr, dm_addr, io_addr} = {a, a, a, a[10:0]};
        {pm_wdata, dm_wdata, io_wdata} = {wd, wd[15:0], wd[15:0]};
        lat = 0;
        do begin
            @(negedge mclk);
            {io_req, dm_req, pm_req, fetch_req} = 4'h0;
            lat++;
        end while (acks[k] !== 1'b1 && lat < 40);
        rd = k == 0 ? fetch_rdata : k == 1 ? pm_rdata :
             k == 2 ? {8'h0, dm_rdata} : {8'h0, io_rdata};
    endtask
    task automatic wr_rd(input int k, input logic [13:0] a,
                         input logic [23:0] wd, input int el, input string nm);
        logic [23:0] r;
        int          l;
        acc(k, 1'b1, a, wd, r, l);
        chk({nm, " wr cycles"}, 24'(el), 24'(l));
        acc(k, 1'b0, a, 24'h0, r, l);
        chk({nm, " rd cycles"}, 24'(el), 24'(l));
        chk({nm, " data"}, wd, r);
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_dm_int;
        logic [23:0] r;
        int          l;
        wr_rd(2, 14'h2005, 24'h00beef, 1, "dm int");
        acc(2, 1'b0, 14'h0005, 24'h0, r, l);
        chk("dm alias", 24'h00beef, r);
        acc(2, 1'b0, 14'h1fe5, 24'h0, r, l);
        chk("dm past 8160", 24'h0, r);
        wr_rd(2, 14'h3fdf, 24'h001234, 1, "dm top ram");
        for (int i = 0; i < 2; i++) begin
            acc(2, 1'b0, i ? 14'h3fff : 14'h3fe0, 24'h0, r, l);
            chk("mmr cycles", 24'h2, 24'(l));
            chk("mmr data", {8'h0, 16'ha500 | (i ? 16'h1f : 16'h0)}, r);
        end
        $display("t_dm_int done");
    endtask
    task automatic t_dual;
        logic [23:0] r;
        int          l;
        acc(1, 1'b1, 14'h0040, 24'h123456, r, l);
        acc(1, 1'b1, 14'h0041, 24'h654321, r, l);
        @(negedge mclk);
        {fetch_req, pm_req, pm_we} = 3'b110;
        {fetch_addr, pm_addr} = {14'h0040, 14'h0041};
        @(negedge mclk);
        {fetch_req, pm_req} = 2'b00;
        chk("dual acks", 24'h3, {22'h0, fetch_ack, pm_ack});
        chk("dual fetch", 24'h123456, fetch_rdata);
        chk("dual pm", 24'h654321, pm_rdata);
        $display("t_dual done");
    endtask
    task automatic t_ext;
        logic [23:0] r;
        int          l;
        for (int ov = 1; ov < 3; ov++) begin
            data_overlay_select = 2'(ov);
            program_overlay_select = 2'(ov);
            wr_rd(2, 14'h0123, 24'h1100 | ov, 7, "dm ext");
            wr_rd(1, 14'h2abc, 24'h5a0000 | ov, 6, "pm ext");
        end
        data_overlay_select = OVL_ONE;
        acc(2, 1'b0, 14'h0123, 24'h0, r, l);
        chk("dm overlay 1", 24'h001101, r);
        program_overlay_select = OVL_TWO;
        acc(0, 1'b0, 14'h2abc, 24'h0, r, l);
        chk("fetch overlay 2", 24'h5a0002, r);
        data_overlay_select = OVL_NONE;
        program_overlay_select = OVL_NONE;
        $display("t_ext done");
    endtask
    task automatic t_io;
        for (int i = 0; i < 4; i++) begin
            wr_rd(3, 14'(i * 512 + (i % 2 ? 0 : 511)), 24'hc000 | i,
                  int'(WT[i]) + 5, "io");
        end
        $display("t_io done");
    endtask
    task automatic t_strap;
        logic [23:0] r;
        int          l;
        mode_b_pin = 1'b1;
        repeat (4) @(negedge mclk);
        wr_rd(1, 14'h0010, 24'h777777, 6, "pm strap");
        acc(1, 1'b0, 14'h2010, 24'h0, r, l);
        chk("pm reserved", 24'h0, r);
        mode_b_pin = 1'b0;
        repeat (4) @(negedge mclk);
        acc(1, 1'b0, 14'h0010, 24'h0, r, l);
        chk("pm strap low", 24'h1, 24'(l));
        $display("t_strap done");
    endtask
    task automatic stop_test;
        $display("Tests %0d, errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    initial begin
        repeat (6000) @(posedge mclk);
        n_errors++;
        stop_test;
    end
    initial begin
        {rst_b, mode_b_pin, fetch_req, pm_req, dm_req, io_req} = 6'h0;
        {pm_we, dm_we, io_we, program_overlay_select} = 5'h0;
        data_overlay_select = OVL_NONE;
        data_ext_wait_count = 3'h2;
        {fetch_addr, pm_addr, dm_addr, io_addr} = '0;
        {pm_wdata, dm_wdata, io_wdata} = '0;
        repeat (8) @(negedge mclk);
        rst_b = 1'b1;
        repeat (4) @(negedge mclk);
        t_dm_int;
        t_dual;
        t_ext;
        t_io;
        t_strap;
        stop_test;
    end
endmodule // mmod_decoder_bench
`default_nettype wire
